// ===== verilog/sfw_consts.svh
`ifndef SFW_CONSTS_SVH
`define SFW_CONSTS_SVH
`define SFW_OP_LSET  8'h06
`define SFW_OP_LCLR  8'h04
`define SFW_OP_SW1   8'h01
`define SFW_OP_SW2   8'h31
`define SFW_OP_SW3   8'h11
`define SFW_OP_PROG  8'h02
`define SFW_OP_QPROG 8'h32
`define SFW_OP_W4K   8'h20
`define SFW_OP_W32K  8'h52
`define SFW_OP_W64K  8'hd8
`define SFW_OP_WALL  8'hc7
`define SFW_OP_SLEEP 8'hb9
`define SFW_OP_WAKE  8'hab
`define SFW_OP_RSR1  8'h05
`define SFW_OP_RSR2  8'h35
`define SFW_OP_READ  8'h03
`define SFW_OP_FREAD 8'h0b
`define SFW_OP_DOUT  8'h3b
`define SFW_OP_DIO   8'hbb
`define SFW_OP_QIO   8'heb
`define SFW_SR_BUSY   0
`define SFW_SR_WEL    1
`define SFW_SR_BP_LO  2
`define SFW_SR_BP_HI  4
`define SFW_SR_BOT    5
`define SFW_SR_G4K    6
`define SFW_SR_LOCK   7
`define SFW_SR2_LOCKH 0
`define SFW_SR2_INV   6
`define SFW_W1 3'h1
`define SFW_W2 3'h2
`define SFW_W4 3'h4
`define SFW_OE_OFF 4'hf
`define SFW_OE_W1  4'hd
`define SFW_OE_W2  4'hc
`define SFW_OE_W4  4'h0
`define SFW_BYTE_CLKS 5'h08
`define SFW_ADDR_CLKS 5'h18
`define SFW_DUM_FAST  5'h08
`define SFW_DUM_DIO   5'h04
`define SFW_DUM_QIO   5'h06
`define SFW_M_PAGE 21'h0000ff
`define SFW_M_4K   21'h000fff
`define SFW_M_32K  21'h007fff
`define SFW_M_64K  21'h00ffff
`define SFW_M_ALL  21'h1fffff
`define SFW_SH_4K  5'h0c
`define SFW_SH_64K 5'h10
`define SFW_PUW_US  1000
`define SFW_CLK_MHZ 250
`endif

// ===== verilog/sfw_pkg.sv
package sfw_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUM, PH_DIN, PH_DOUT, PH_IGN} sfw_phase_e;
  typedef enum logic [2:0] {K_STATUS, K_PROG, K_W4K, K_W32K, K_W64K, K_WALL} sfw_kind_e;
  typedef struct packed {
    logic [2:0]       cs_s;
    logic [2:0]       ck_s;
    logic [2:0][3:0]  dq_s;
    logic             cs_l;
    logic             ck_l;
    sfw_phase_e       ph;
    logic [7:0]       op;
    logic [7:0]       sh;
    logic [4:0]       cnt;
    logic [2:0]       tot8;
    logic [2:0]       aw;
    logic [2:0]       dw;
    logic [4:0]       dum;
    logic             adone;
    logic             nbyte;
    logic [7:0]       sr_in;
    logic [23:0]      addr;
    logic [7:0]       ob;
    logic [3:0]       dq_o;
    logic [3:0]       oe_n;
    logic             write_enable_latch;
    logic             busy;
    logic             sleep;
    logic [2:0]       bp;
    logic             bot;
    logic             g4k;
    logic             lock;
    logic             lockh;
    logic             inv;
    logic [31:0]      puw;
    logic             puw_done;
    logic             drop;
    logic             start;
    logic             cancel;
    logic             rd_req;
    sfw_kind_e        kind;
    logic [23:0]      op_addr;
    logic             push;
    logic [7:0]       push_d;
  } sfw_state_s;
endpackage : sfw_pkg

// ===== verilog/sfw_top.sv
`include "sfw_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module sfw_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_flush,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  // D must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } sfw_fifo_s;
  sfw_fifo_s q;
  sfw_fifo_s n;
  logic      pu;
  logic      po;

  assign o_ready = q.cnt != (AW+1)'(D);
  assign o_valid = q.cnt != '0;
  assign o_data  = q.mem[q.rp];

  always_comb begin
    n  = q;
    pu = i_valid & o_ready;
    po = o_valid & i_ready;
    if (pu) begin
      n.mem[q.wp] = i_data;
      n.wp        = q.wp + 1'b1;
    end
    if (po) begin
      n.rp = q.rp + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(pu) - (AW+1)'(po);
    if (i_flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : sfw_fifo

////////////////////////////////////////////////////////////////////////////////
module sfw_top #(
  parameter int PUW_CYC = `SFW_PUW_US * `SFW_CLK_MHZ,
  parameter int FIFO_D  = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_sclk,
  input  wire logic         i_cs_n,
  input  wire logic [3:0]   i_dq,
  output logic [3:0]        o_dq,
  output logic [3:0]        o_dq_oe_n,
  output logic [7:0]        o_status1,
  output logic [7:0]        o_status2,
  output logic              o_active,
  output logic              o_deep_sleep,
  output logic              o_op_start,
  output logic              o_op_cancel,
  output sfw_pkg::sfw_kind_e o_op_kind,
  output logic [23:0]       o_op_addr,
  input  wire logic         i_op_done,
  output logic              o_rd_req,
  output logic [23:0]       o_rd_addr,
  input  wire logic [7:0]   i_rd_data,
  output logic              o_wr_valid,
  output logic [7:0]        o_wr_data,
  input  wire logic         i_wr_ready
);
  localparam sfw_pkg::sfw_state_s RST = '{oe_n: `SFW_OE_OFF, cs_l: 1'b1, ph: sfw_pkg::PH_IDLE,
                                          kind: sfw_pkg::K_STATUS, default: '0};
  sfw_pkg::sfw_state_s q;
  sfw_pkg::sfw_state_s n;
  logic               rise;
  logic               fall;
  logic               cs_up;
  logic               cs_dn;
  logic               rd_op;
  logic               good;
  logic               wok;
  logic               lockd;
  logic               hit;
  logic               fifo_rdy;
  logic [4:0]         lim_b;
  logic [4:0]         lim_a;
  logic [20:0]        mask;
  logic [7:0]         sr1;
  logic [7:0]         sr2;
  logic [7:0]         byt;
  sfw_pkg::sfw_kind_e kind;

  // Most significant bit first over 1, 2 or 4 lanes
  function automatic logic [23:0] shin(input logic [23:0] v, input logic [3:0] d,
                                       input logic [2:0] w);
    case (w)
      `SFW_W4: return {v[19:0], d};
      `SFW_W2: return {v[21:0], d[1:0]};
      default: return {v[22:0], d[0]};
    endcase
  endfunction : shin

  // Protected range from the level bits, complemented when inverted
  function automatic logic prot_hit(input logic [2:0] bp, input logic bot, input logic g4k,
                                    input logic inv, input logic [20:0] s,
                                    input logic [20:0] e);
    logic [4:0]  sh;
    logic [20:0] sz;
    logic [20:0] lo;
    logic [20:0] hi;
    logic        none;
    logic        all;
    logic        ovl;
    logic        ins;
    sh   = (g4k ? `SFW_SH_4K : `SFW_SH_64K) + {2'h0, (g4k && bp[2]) ? 3'h3 : bp - 3'h1};
    sz   = 21'((22'h1 << sh) - 22'h1);
    lo   = bot ? 21'h0 : ~sz;
    hi   = bot ? sz : `SFW_M_ALL;
    none = bp == 3'h0;
    all  = bp[2] & bp[1];
    ovl  = all | (~none & (s <= hi) & (e >= lo));
    ins  = all | (~none & (s >= lo) & (e <= hi));
    return inv ? ~ins : ovl;
  endfunction : prot_hit

  sfw_fifo #(
    .W (8),
    .D (FIFO_D)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_flush    (q.cancel),
    .i_valid    (q.push),
    .o_ready    (fifo_rdy),
    .i_data     (q.push_d),
    .o_valid    (o_wr_valid),
    .i_ready    (i_wr_ready),
    .o_data     (o_wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = q;
    n.start  = 1'b0;
    n.cancel = 1'b0;
    n.rd_req = 1'b0;
    n.push   = 1'b0;
    byt      = q.ob;
    n.cs_s   = {q.cs_s[1:0], i_cs_n};
    n.ck_s   = {q.ck_s[1:0], i_sclk};
    n.dq_s   = {q.dq_s[1:0], i_dq};
    // Level counts once stages two and three agree
    if (q.cs_s[2] == q.cs_s[1]) begin
      n.cs_l = q.cs_s[2];
    end
    if (q.ck_s[2] == q.ck_s[1]) begin
      n.ck_l = q.ck_s[2];
    end
    // Edges only, so the idle clock level does not matter
    rise  = n.ck_l & ~q.ck_l;
    fall  = ~n.ck_l & q.ck_l;
    cs_up = n.cs_l & ~q.cs_l;
    cs_dn = ~n.cs_l & q.cs_l;
    lim_b = `SFW_BYTE_CLKS >> (q.dw >> 1);
    lim_a = `SFW_ADDR_CLKS >> (q.aw >> 1);
    rd_op = q.op inside {`SFW_OP_READ, `SFW_OP_FREAD, `SFW_OP_DOUT, `SFW_OP_DIO, `SFW_OP_QIO};
    sr1   = 8'h0;
    sr1[`SFW_SR_BUSY] = q.busy;
    sr1[`SFW_SR_WEL]  = q.write_enable_latch;
    sr1[`SFW_SR_BP_HI:`SFW_SR_BP_LO] = q.bp;
    sr1[`SFW_SR_BOT]  = q.bot;
    sr1[`SFW_SR_G4K]  = q.g4k;
    sr1[`SFW_SR_LOCK] = q.lock;
    sr2   = 8'h0;
    sr2[`SFW_SR2_LOCKH] = q.lockh;
    sr2[`SFW_SR2_INV]   = q.inv;
    case (q.op)
      `SFW_OP_W4K: begin
        mask = `SFW_M_4K;
        kind = sfw_pkg::K_W4K;
      end
      `SFW_OP_W32K: begin
        mask = `SFW_M_32K;
        kind = sfw_pkg::K_W32K;
      end
      `SFW_OP_W64K: begin
        mask = `SFW_M_64K;
        kind = sfw_pkg::K_W64K;
      end
      `SFW_OP_WALL: begin
        mask = `SFW_M_ALL;
        kind = sfw_pkg::K_WALL;
      end
      default: begin
        mask = `SFW_M_PAGE;
        kind = sfw_pkg::K_PROG;
      end
    endcase
    hit   = prot_hit(q.bp, q.bot, q.g4k, q.inv, q.addr[20:0] & ~mask, q.addr[20:0] | mask);
    good  = (q.tot8 == 3'h0) & q.puw_done & ~q.busy & ~q.sleep;
    wok   = good & q.write_enable_latch;
    lockd = q.lockh | (q.lock & ~q.dq_s[2][2]);

    if (!q.puw_done) begin
      n.puw      = q.puw + 32'h1;
      n.puw_done = q.puw == 32'(PUW_CYC - 1);
    end
    if (q.busy && i_op_done) begin
      n.busy = 1'b0;
      n.write_enable_latch  = 1'b0;
    end
    // Overflow spoils the page; program is cancelled at deselect
    if (q.push && !fifo_rdy) begin
      n.drop = 1'b1;
    end

    if (cs_dn) begin
      n.ph    = sfw_pkg::PH_CMD;
      n.cnt   = 5'h0;
      n.tot8  = 3'h0;
      n.adone = 1'b0;
      n.nbyte = 1'b0;
      n.drop  = 1'b0;
      n.aw    = `SFW_W1;
      n.dw    = `SFW_W1;
    end else if (rise && !q.cs_l) begin
      n.cnt  = q.cnt + 5'h1;
      n.tot8 = q.tot8 + 3'h1;
      case (q.ph)
        sfw_pkg::PH_CMD: begin
          n.sh = 8'(shin({16'h0, q.sh}, q.dq_s[2], `SFW_W1));
          if (q.cnt == `SFW_BYTE_CLKS - 5'h1) begin
            n.op  = n.sh;
            n.cnt = 5'h0;
            n.ph  = sfw_pkg::PH_ADDR;
            n.aw  = `SFW_W1;
            n.dw  = `SFW_W1;
            n.dum = 5'h0;
            case (n.sh)
              `SFW_OP_FREAD: n.dum = `SFW_DUM_FAST;
              `SFW_OP_DOUT: begin
                n.dw  = `SFW_W2;
                n.dum = `SFW_DUM_FAST;
              end
              `SFW_OP_DIO: begin
                n.aw  = `SFW_W2;
                n.dw  = `SFW_W2;
                n.dum = `SFW_DUM_DIO;
              end
              `SFW_OP_QIO: begin
                n.aw  = `SFW_W4;
                n.dw  = `SFW_W4;
                n.dum = `SFW_DUM_QIO;
              end
              `SFW_OP_QPROG: n.dw = `SFW_W4;
              `SFW_OP_READ, `SFW_OP_PROG, `SFW_OP_W4K, `SFW_OP_W32K, `SFW_OP_W64K: ;
              `SFW_OP_SW1, `SFW_OP_SW2, `SFW_OP_SW3: n.ph = sfw_pkg::PH_DIN;
              `SFW_OP_RSR1, `SFW_OP_RSR2: n.ph = sfw_pkg::PH_DOUT;
              default: n.ph = sfw_pkg::PH_IGN;
            endcase
            if (q.sleep) begin
              n.ph = sfw_pkg::PH_IGN;
            end
          end
        end
        sfw_pkg::PH_ADDR: begin
          n.addr = shin(q.addr, q.dq_s[2], q.aw);
          if (q.cnt == lim_a - 5'h1) begin
            n.cnt    = 5'h0;
            n.adone  = 1'b1;
            n.ph     = (q.dum != 5'h0) ? sfw_pkg::PH_DUM :
                       rd_op ? sfw_pkg::PH_DOUT : sfw_pkg::PH_DIN;
            n.rd_req = rd_op & (q.dum == 5'h0);
          end
        end
        sfw_pkg::PH_DUM: begin
          if (q.cnt == q.dum - 5'h1) begin
            n.cnt    = 5'h0;
            n.ph     = sfw_pkg::PH_DOUT;
            n.rd_req = 1'b1;
          end
        end
        sfw_pkg::PH_DIN: begin
          n.sh = 8'(shin({16'h0, q.sh}, q.dq_s[2], q.dw));
          if (q.cnt == lim_b - 5'h1) begin
            n.cnt   = 5'h0;
            n.nbyte = 1'b1;
            if (!q.nbyte) begin
              n.sr_in = n.sh;
            end
            if (q.op == `SFW_OP_PROG || q.op == `SFW_OP_QPROG) begin
              n.push   = 1'b1;
              n.push_d = n.sh;
            end
          end
        end
        sfw_pkg::PH_DOUT: begin
          if (q.cnt == lim_b - 5'h1) begin
            n.cnt    = 5'h0;
            n.addr   = q.addr + 24'h1;
            n.rd_req = rd_op;
          end
        end
        default: ;
      endcase
    end else if (fall && !q.cs_l && q.ph == sfw_pkg::PH_DOUT) begin
      if (q.cnt == 5'h0) begin
        byt = rd_op ? i_rd_data : (q.op == `SFW_OP_RSR2) ? sr2 : sr1;
      end
      case (q.dw)
        `SFW_W4: begin
          n.dq_o = byt[7:4];
          n.ob   = {byt[3:0], 4'h0};
          n.oe_n = `SFW_OE_W4;
        end
        `SFW_W2: begin
          n.dq_o = {2'h0, byt[7:6]};
          n.ob   = {byt[5:0], 2'h0};
          n.oe_n = `SFW_OE_W2;
        end
        default: begin
          n.dq_o = {2'h0, byt[7], 1'b0};
          n.ob   = {byt[6:0], 1'b0};
          n.oe_n = `SFW_OE_W1;
        end
      endcase
    end

    // Instructions act only once select rises after the last bit
    if (cs_up && q.ph != sfw_pkg::PH_IDLE) begin
      n.ph   = sfw_pkg::PH_IDLE;
      n.oe_n = `SFW_OE_OFF;
      case (q.op)
        `SFW_OP_LSET: if (good) n.write_enable_latch = 1'b1;
        `SFW_OP_LCLR: if (good) n.write_enable_latch = 1'b0;
        `SFW_OP_SW1, `SFW_OP_SW2, `SFW_OP_SW3: begin
          if (wok && q.nbyte && !lockd) begin
            n.busy  = 1'b1;
            n.start = 1'b1;
            n.kind  = sfw_pkg::K_STATUS;
            if (q.op == `SFW_OP_SW1) begin
              n.bp   = q.sr_in[`SFW_SR_BP_HI:`SFW_SR_BP_LO];
              n.bot  = q.sr_in[`SFW_SR_BOT];
              n.g4k  = q.sr_in[`SFW_SR_G4K];
              n.lock = q.sr_in[`SFW_SR_LOCK];
            end else if (q.op == `SFW_OP_SW2) begin
              n.lockh = q.sr_in[`SFW_SR2_LOCKH];
              n.inv   = q.sr_in[`SFW_SR2_INV];
            end
          end
        end
        `SFW_OP_PROG, `SFW_OP_QPROG: begin
          if (wok && q.nbyte && !q.drop && !hit) begin
            n.busy    = 1'b1;
            n.start   = 1'b1;
            n.kind    = kind;
            n.op_addr = q.addr;
          end else begin
            n.cancel = 1'b1;
          end
        end
        `SFW_OP_W4K, `SFW_OP_W32K, `SFW_OP_W64K, `SFW_OP_WALL: begin
          if (wok && (q.adone || q.op == `SFW_OP_WALL) && !hit) begin
            n.busy    = 1'b1;
            n.start   = 1'b1;
            n.kind    = kind;
            n.op_addr = q.addr;
          end
        end
        `SFW_OP_SLEEP: if (good) n.sleep = 1'b1;
        `SFW_OP_WAKE: n.sleep = 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign o_dq         = q.dq_o;
  assign o_dq_oe_n    = q.oe_n;
  assign o_status1    = sr1;
  assign o_status2    = sr2;
  assign o_active     = ~q.cs_l | q.busy;
  assign o_deep_sleep = q.sleep;
  assign o_op_start   = q.start;
  assign o_op_cancel  = q.cancel;
  assign o_op_kind    = q.kind;
  assign o_op_addr    = q.op_addr;
  assign o_rd_req     = q.rd_req;
  assign o_rd_addr    = q.addr;
endmodule : sfw_top

// ===== verif/sfw_top_assertions.sv
module sfw_top_chk #(
  parameter int PUW_CYC = 250000
) (
  input wire logic       i_core_clk,
  input wire logic       i_arst_n,
  input wire logic       i_cs_n,
  input wire logic       i_op_done,
  input wire logic [3:0] o_dq_oe_n,
  input wire logic [7:0] o_status1,
  input wire logic       o_active,
  input wire logic       o_deep_sleep,
  input wire logic       o_op_start,
  input wire logic       o_op_cancel
);
  logic [31:0] cyc_q;
  logic [31:0] cyc_d;

  // Saturates, so a long run never wraps back under the delay
  always_comb begin
    cyc_d = (cyc_q == 32'hffffffff) ? cyc_q : cyc_q + 32'h1;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_q <= 32'h0;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  ////////////////////////////////////////////////
  chk_oe_code: assert property (o_dq_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("bad enable pattern");
  chk_oe_desel: assert property (i_cs_n [*8] |-> o_dq_oe_n == 4'hf)
    else $error("driving while deselected");
  chk_busy_set: assert property (o_op_start |=> o_status1[0])
    else $error("busy not set");
  chk_busy_cause: assert property ($rose(o_status1[0]) |-> o_op_start || $past(o_op_start))
    else $error("busy without start");
  chk_busy_hold: assert property (o_status1[0] && !i_op_done |=> o_status1[0])
    else $error("busy dropped early");
  chk_done_clear: assert property (o_status1[0] && i_op_done |=> o_status1[1:0] == 2'b00)
    else $error("busy or latch kept");
  chk_start_latch: assert property (o_op_start |-> o_status1[1])
    else $error("start without latch");
  chk_start_awake: assert property (o_op_start |-> !o_deep_sleep && !o_op_cancel)
    else $error("start while asleep");
  chk_idle_standby: assert property ((i_cs_n && !o_status1[0]) [*8] |-> !o_active)
    else $error("active while idle");
  chk_puw_wait: assert property (o_op_start |-> cyc_q >= 32'(PUW_CYC))
    else $error("start too early");

  cov_start: cover property (o_op_start);
  cov_cancel: cover property (o_op_cancel);
  cov_sleep: cover property ($rose(o_deep_sleep));
endmodule : sfw_top_chk

bind sfw_top sfw_top_chk #(.PUW_CYC(PUW_CYC)) u_chk (
  .i_core_clk   (i_core_clk),
  .i_arst_n     (i_arst_n),
  .i_cs_n       (i_cs_n),
  .i_op_done    (i_op_done),
  .o_dq_oe_n    (o_dq_oe_n),
  .o_status1    (o_status1),
  .o_active     (o_active),
  .o_deep_sleep (o_deep_sleep),
  .o_op_start   (o_op_start),
  .o_op_cancel  (o_op_cancel)
);

// ===== verif/sfw_host.sv
module sfw_host (
  input  wire logic       i_core_clk,
  input  wire logic [3:0] i_dq,
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mode3 = 1'b0;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq   = 4'hc;
  end

  // Half period of the link clock, 80 ns
  task automatic hp();
    repeat (20) @(posedge i_core_clk);
    #1;
  endtask : hp

  // Lanes 3:2 stay high outside quad: hold and write-protect idle
  task automatic frame(input logic [127:0] tx, input int n, input int wa,
                       input int nd, input int w, output logic [7:0] rx);
    int i;
    int b;
    rx = 8'h00;
    o_sclk = mode3;
    hp();
    o_cs_n = 1'b0;
    hp();
    i = 0;
    while (i < n) begin
      b = (i < 8) ? 1 : wa;
      o_sclk = 1'b0;
      if (b == 4) o_dq = tx[n-1-i -: 4];
      else if (b == 2) o_dq = {2'h3, tx[n-1-i -: 2]};
      else o_dq = {3'h6, tx[n-1-i]};
      hp();
      o_sclk = 1'b1;
      hp();
      i = i + b;
    end
    // Width zero: write frame, no read-back clocks
    for (i = 0; w != 0 && i < nd + 8 / w; i++) begin
      o_sclk = 1'b0;
      // Released lanes toggle so a stale value cannot pass
      if (i < nd) o_dq = (w == 4) ? 4'h0 : 4'hc;
      else o_dq = o_dq ^ ((w == 4) ? 4'hf : 4'h3);
      hp();
      o_sclk = 1'b1;
      if (i >= nd) begin
        rx = (w == 1) ? {rx[6:0], i_dq[1]} : (w == 2) ? {rx[5:0], i_dq[1:0]} : {rx[3:0], i_dq};
      end
      hp();
    end
    o_sclk = mode3;
    hp();
    o_cs_n = 1'b1;
    o_dq = {2'h3, ~o_dq[1:0]};
    repeat (3) hp();
  endtask : frame
endmodule : sfw_host

// ===== verif/sfw_top_tb.sv
module sfw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PUW = 2000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_done = 1'b0;
  logic wr_rdy = 1'b1;
  logic [7:0] rd_data = 8'h00;
  logic [3:0] dq_o, oe_n, hdq, dq_w, oe_last;
  logic [7:0] st1, st2, wr_d, rx;
  logic sclk, cs_n, act, slp, start, cancel, rd_req, wr_v;
  logic [23:0] op_addr, rd_addr, la;
  sfw_pkg::sfw_kind_e kind, lk;
  logic [7:0] popq[$];
  int err_total = 0;
  int compares = 0;
  int nst = 0;
  int ncan = 0;
  int dcnt = 0;
  int cyc = 0;

  sfw_top #(.PUW_CYC(PUW), .FIFO_D(8)) dut (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_dq(dq_w),
    .o_dq(dq_o), .o_dq_oe_n(oe_n), .o_status1(st1), .o_status2(st2), .o_active(act),
    .o_deep_sleep(slp), .o_op_start(start), .o_op_cancel(cancel), .o_op_kind(kind),
    .o_op_addr(op_addr), .i_op_done(op_done), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .o_wr_valid(wr_v), .o_wr_data(wr_d), .i_wr_ready(wr_rdy)
  );
  sfw_host h (.i_core_clk(clk), .i_dq(dq_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_dq(hdq));

  always_comb begin
    for (int k = 0; k < 4; k++) dq_w[k] = oe_n[k] ? hdq[k] : dq_o[k];
  end

  initial begin
    forever #2 clk = ~clk;
  end

  // Array side: long busy so the flag can be seen after each frame
  always @(posedge clk) begin
    #1;
    op_done = (dcnt == 1);
    if (dcnt != 0) dcnt--;
    if (start) dcnt = 200;
    if (rd_req) rd_data = rd_addr[7:0] ^ 8'h5a;
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      final_report();
    end
  end

  always @(negedge clk) begin
    if (wr_v && wr_rdy) popq.push_back(wr_d);
    if (start) begin
      nst++;
      lk = kind;
      la = op_addr;
    end
    if (cancel) ncan++;
    if (oe_n != 4'hf) oe_last = oe_n;
  end

  ////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk

  task automatic op(input logic [127:0] tx, input int n);
    h.frame(tx, n, 1, 0, 0, rx);
  endtask : op

  task automatic wait_idle();
    for (int i = 0; i < 400 && st1[0] !== 1'b0; i++) @(posedge clk);
    @(posedge clk);
    #1;
    chk("busy", 32'h0, 32'(st1[0]));
  endtask : wait_idle

  task automatic t_boot();
    chk("oe", 32'hf, 32'(oe_n));
    chk("status", 32'h0, 32'({st2, st1}));
    chk("active", 32'h0, 32'(act));
    op(128'h06, 8);
    chk("puw latch", 32'h0, 32'(st1[1]));
    op({8'h20, 24'h000000}, 32);
    chk("early", 32'h0, 32'(nst));
    repeat (PUW) @(posedge clk);
    #1;
    op(128'h04, 8);
    chk("latch", 32'h0, 32'(st1[1]));
  endtask : t_boot

  task automatic t_erase();
    logic [7:0] opc[4] = '{8'h20, 8'h52, 8'hd8, 8'hc7};
    logic [23:0] ad[4] = '{24'h1ff000, 24'h1f8000, 24'h1f0000, 24'h0};
    sfw_pkg::sfw_kind_e kd[4] = '{sfw_pkg::K_W4K, sfw_pkg::K_W32K, sfw_pkg::K_W64K,
                                  sfw_pkg::K_WALL};
    int s;
    for (int k = 0; k < 4; k++) begin
      h.mode3 = k[0];
      s = nst;
      op(128'h06, 8);
      chk("latch", 32'h1, 32'(st1[1]));
      op(k == 3 ? 128'hc7 : 128'({opc[k], ad[k]}), k == 3 ? 8 : 32);
      chk("start", 32'(s + 1), 32'(nst));
      chk("kind", 32'(kd[k]), 32'(lk));
      if (k < 3) chk("addr", 32'(ad[k]), 32'(la));
      chk("busy", 32'h1, 32'(st1[0]));
      chk("active", 32'h1, 32'(act));
      wait_idle();
      chk("latch", 32'h0, 32'(st1[1]));
      chk("standby", 32'h0, 32'(act));
    end
  endtask : t_erase

  task automatic t_refuse();
    int s;
    s = nst;
    op({8'h20, 24'h001000}, 32);
    chk("nolatch", 32'(s), 32'(nst));
    op(128'h06, 8);
    op({8'h20, 24'h001000, 1'b0}, 33);
    chk("count", 32'(s), 32'(nst));
    op(128'hb9, 8);
    chk("sleep", 32'h1, 32'(slp));
    op(128'h04, 8);
    op({8'h20, 24'h001000}, 32);
    chk("asleep", 32'(s), 32'(nst));
    chk("latch", 32'h1, 32'(st1[1]));
    op(128'hab, 8);
    chk("wake", 32'h0, 32'(slp));
    op(128'h04, 8);
    chk("clear", 32'h0, 32'(st1[1]));
  endtask : t_refuse

  task automatic t_protect();
    int s;
    op(128'h06, 8);
    op({8'h01, 8'h04}, 16);
    chk("kind", 32'(sfw_pkg::K_STATUS), 32'(lk));
    wait_idle();
    chk("level", 32'h1, 32'(st1[4:2]));
    s = nst;
    op(128'h06, 8);
    op({8'h20, 24'h1ff000}, 32);
    chk("locked", 32'(s), 32'(nst));
    op(128'h06, 8);
    op({8'h20, 24'h1ef000}, 32);
    chk("open", 32'(s + 1), 32'(nst));
    wait_idle();
    op(128'h06, 8);
    op({8'h01, 8'h00}, 16);
    wait_idle();
    chk("level", 32'h0, 32'(st1[4:2]));
  endtask : t_protect

  task automatic t_prog();
    int c;
    popq.delete();
    wr_rdy = 1'b0;
    op(128'h06, 8);
    op({8'h02, 24'h012300, 8'ha5, 8'h3c}, 48);
    chk("kind", 32'(sfw_pkg::K_PROG), 32'(lk));
    chk("addr", 32'h012300, 32'(la));
    wr_rdy = 1'b1;
    wait_idle();
    chk("pops", 32'h2, 32'(popq.size()));
    if (popq.size() == 2) begin
      chk("byte0", 32'ha5, 32'(popq[0]));
      chk("byte1", 32'h3c, 32'(popq[1]));
    end
    // Nine bytes against eight slots with the drain stalled
    wr_rdy = 1'b0;
    c = ncan;
    op(128'h06, 8);
    op({8'h02, 24'h0, 72'h010203040506070809}, 104);
    chk("cancel", 32'(c + 1), 32'(ncan));
    chk("flush", 32'h0, 32'(wr_v));
    wr_rdy = 1'b1;
    op(128'h04, 8);
  endtask : t_prog

  task automatic t_read();
    logic [7:0] opc[5] = '{8'h03, 8'h3b, 8'heb, 8'h0b, 8'hbb};
    logic [3:0] oe[5] = '{4'hd, 4'hc, 4'h0, 4'hd, 4'hc};
    int nd[5] = '{0, 8, 6, 8, 4};
    int w[5] = '{1, 2, 4, 1, 2};
    int wa[5] = '{1, 1, 4, 1, 2};
    op(128'h06, 8);
    h.frame(128'h05, 8, 1, 0, 1, rx);
    chk("sr1", 32'h02, 32'(rx));
    op(128'h04, 8);
    for (int k = 0; k < 5; k++) begin
      h.mode3 = ~k[0];
      oe_last = 4'hf;
      h.frame({opc[k], 24'h0001a7}, 32, wa[k], nd[k], w[k], rx);
      chk("rdata", 32'hfd, 32'(rx));
      chk("lanes", 32'(oe[k]), 32'(oe_last));
    end
  endtask : t_read

  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_boot();
    t_erase();
    t_refuse();
    t_protect();
    t_prog();
    t_read();
    final_report();
  end
endmodule : sfw_top_tb
